/* File: scx_pkg.sv */
// Shared constants and types for the serial configuration and receive sequencer
package scx_pkg;
    // Frame layout, sent most significant bit first
    localparam int FRAME_BITS = 16;
    localparam int CMD_MSB = 15;
    localparam int CMD_LSB = 12;
    localparam int ADDR_MSB = 11;
    localparam int ADDR_LSB = 8;
    localparam int DATA_MSB = 7;
    localparam int DATA_LSB = 0;
    localparam int ADDR_W = 4;
    localparam int BYTE_IDX_W = 3;
    localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
    localparam logic [4:0] BIT_LAST = 5'h0f;
    localparam logic [4:0] FRAME_END = 5'h10;

    // Command codes
    localparam logic [3:0] CMD_WRITE = 4'h1;
    localparam logic [3:0] CMD_READ = 4'h2;
    localparam logic [3:0] CMD_MRESET = 4'h3;

    // Register map
    localparam int REG_COUNT = 11;
    localparam logic [3:0] ADDR_PWR = 4'h0;
    localparam logic [3:0] ADDR_CFG = 4'h1;
    localparam logic [3:0] ADDR_CTL = 4'h2;
    localparam logic [3:0] ADDR_XDIV = 4'h3;
    localparam logic [3:0] ADDR_OFF_HI = 4'h4;
    localparam logic [3:0] ADDR_OFF_LO = 4'h5;
    localparam logic [3:0] ADDR_CPU = 4'h6;
    localparam logic [3:0] ADDR_RF_HI = 4'h7;
    localparam logic [3:0] ADDR_RF_LO = 4'h8;
    localparam logic [3:0] ADDR_STAT = 4'h9;
    localparam logic [3:0] ADDR_DWELL = 4'ha;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DWELL = 8'h0d;

    // Field positions
    localparam int PWR_SLEEP_BIT = 0;
    localparam int PWR_EN_LSB = 1;
    localparam int PWR_EN_MSB = 7;
    localparam int PWR_APD_BIT = 1;
    localparam int PWR_FPD_BIT = 2;
    localparam int CFG_DRX_BIT = 0;
    localparam int CFG_FREQ_RB_BIT = 1;
    localparam int CFG_AMPL_RB_BIT = 2;
    localparam int CTL_FREQ_TRK_BIT = 0;
    localparam int CTL_AMPL_TRK_BIT = 1;

    // Timing: internal time base and automatic track pulse
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 10000;
    localparam int TRACK_NS = 20000;
    localparam logic [11:0] TICK_LAST = 12'(TICK_NS / CLK_NS - 1);
    localparam logic [11:0] TRACK_CYC = 12'((TRACK_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [2:0] CHECK_CYC = 3'h4;

    // Discontinuous receive sequence
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OFF = 3'b001,
        ST_CPU = 3'b010,
        ST_RF = 3'b011,
        ST_CHECK = 3'b100,
        ST_ACTIVE = 3'b101
    } scx_drx_e;
endpackage : scx_pkg

/* File: scx_link_if.sv */
// Carrier between the serial clock domain and the core clock domain
`timescale 1ns/10ps
`default_nettype none
interface scx_link_if;
    logic [15:0] frame_word;
    logic frame_done;
    logic [3:0] read_addr;
    logic [7:0] read_byte;
    logic rb_bit;
    modport rx (output frame_word, output frame_done, output read_addr, output rb_bit,
                input read_byte);
    modport core (input frame_word, input frame_done, input read_addr, input rb_bit,
                  output read_byte);
endinterface : scx_link_if
`default_nettype wire

/* File: scx_timer.sv */
// Loadable down counter stepped by the internal time base
`timescale 1ns/10ps
`default_nettype none
module scx_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic tick,
    // Status
    output logic expired
);
    logic [W-1:0] cnt_reg;

    // Count down one step per tick, stop at zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= load_val;
        end else if (tick && cnt_reg != '0) begin
            cnt_reg <= cnt_reg - W'(1);
        end
    end

    assign expired = (cnt_reg == '0);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_timer_step: assert property (tick && !load && cnt_reg != '0 |=> cnt_reg == $past(cnt_reg) - W'(1)) // [R14]
        else $error("timer did not step on tick");
    a_timer_load: assert property (load |=> cnt_reg == $past(load_val)) // [R14]
        else $error("timer did not load");
endmodule : scx_timer
`default_nettype wire

/* File: scx_spi_rx.sv */
// Serial clock domain: frame shifter, address capture and read-back shifter
`timescale 1ns/10ps
`default_nettype none
module scx_spi_rx (
    // Serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    // Core side
    scx_link_if.rx link
);
    logic [4:0] cnt_reg;
    logic [14:0] shift_reg;
    logic [3:0] addr_reg;
    logic [7:0] rb_reg;
    logic [15:0] word_reg;
    logic done_reg;
    logic rb_bit_reg;

    // Frame decode
    wire [15:0] word_now = {shift_reg, sdio_in};
    wire last_bit = (cnt_reg == scx_pkg::BIT_LAST);
    wire addr_bit = (cnt_reg == scx_pkg::BIT_ADDR_LAST);
    wire rd_frame = (word_now[scx_pkg::CMD_MSB:scx_pkg::CMD_LSB] == scx_pkg::CMD_READ);
    wire [2:0] rb_idx = ~cnt_reg[scx_pkg::BYTE_IDX_W-1:0];

    // Bit counter, cleared whenever the port is deselected
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            if (cnt_reg != scx_pkg::FRAME_END) begin // [R8]
                cnt_reg <= cnt_reg + 5'h01;
            end
            if (last_bit) begin
                done_reg <= 1'b1;
            end
        end
    end

    // Data sampled on the rising edge only
    always_ff @(posedge sclk) begin
        shift_reg <= word_now[scx_pkg::FRAME_BITS-2:0]; // [R2] [R3]
        if (addr_bit) begin
            addr_reg <= word_now[scx_pkg::ADDR_W-1:0];
        end
        if (last_bit) begin
            word_reg <= word_now;
        end
        if (last_bit && rd_frame) begin
            rb_reg <= link.read_byte;
        end
    end

    // Read-back bit changes on the falling edge so it is settled at the sample edge
    always_ff @(negedge sclk) begin
        rb_bit_reg <= rb_reg[rb_idx]; // [R6] [R8]
    end

    assign link.frame_word = word_reg;
    assign link.frame_done = done_reg;
    assign link.read_addr = addr_reg;
    assign link.rb_bit = rb_bit_reg;

    default clocking cb @(posedge sclk); endclocking
    default disable iff (cs_n);

    // Checked on the falling edge after the last bit, while select is still low
    a_frame_msb_first: assert property (@(negedge sclk) cnt_reg == scx_pkg::FRAME_END // [R3]
            |-> done_reg && word_reg[scx_pkg::FRAME_BITS-2:0] == shift_reg)
        else $error("frame word not captured msb first");
    a_addr_capture: assert property (addr_bit |=> addr_reg == $past(word_now[scx_pkg::ADDR_W-1:0])) // [R3]
        else $error("address not captured after eighth bit");
endmodule : scx_spi_rx
`default_nettype wire

/* File: scx_sequencer.sv */
// Serial configuration port, register file and discontinuous receive sequencer
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1: Host keeps data line low while deselected.
// R2: Input sampled on serial clock rising edge.
// R3: Frame is command, address, data, MSB first.
// R4: Output-select bit set gives 4-wire read-back.
// R5: Both select bits clear gives 3-wire port.
// R6: 3-wire read drives data line next frame.
// R7: Host releases line during read-back frame.
// R8: Read-back frame may be 8 or 16 clocks.
// R9: Master reset command restores all registers.
// R10: Master reset held until chip select falls.
// R11: Continuous mode powers modules from enable bits.
// R12: Deep-sleep bit overrides every power enable.
// R13: Host writes crystal divisor before calibration.
// R14: Discontinuous mode runs off, recovery, settle timers.
// R15: Host calibrates timers before discontinuous mode.
// R16: Sequence starts when select and line high.
// R17: Off expiry pulls data line low to wake.
// R18: Host drives line low within low window.
// R19: Data outputs enabled only after settle time.
// R20: Host release restarts the off timer.
// R21: Track bits make peak detectors follow input.
// R22: Automatic track pulse on wake and gain switch.
// R23: No host low in window restarts sequence.
// R24: Off timer registers reset to zero.
// R25: Write stores byte; unknown commands ignored.
module scx_sequencer (
    // System clock and synchronous reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial port pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_n,
    output logic sdio_pullup_en,
    // Slicer data and gain switch event from the analog side
    input wire logic ampl_slicer_in,
    input wire logic freq_slicer_in,
    input wire logic agc_gain_switch,
    // Demodulated data pins
    output logic amplitude_data_output,
    output logic frequency_data_output,
    // Analog power and peak detector control
    output logic [7:1] module_power,
    output logic deep_sleep,
    output logic ampl_peak_detector_enable,
    output logic freq_peak_detector_enable,
    output logic ampl_peak_track,
    output logic freq_peak_track
);
    scx_link_if link ();

    // Register file and control state
    logic [7:0] regs_reg [0:scx_pkg::REG_COUNT-1];
    logic [6:0] sync1_reg;
    logic [6:0] sync2_reg;
    logic [2:0] edge_reg;
    logic mreset_reg;
    logic arm_reg;
    logic drive_reg;
    scx_pkg::scx_drx_e state_reg;
    scx_pkg::scx_drx_e state_next;
    logic [11:0] tick_cnt_reg;
    logic [2:0] chk_cnt_reg;
    logic [11:0] trk_cnt_reg;
    logic sdio_out_reg;
    logic sdio_oe_n_reg;
    logic pullup_reg;
    logic ampl_out_reg;
    logic freq_out_reg;
    logic [7:1] power_reg;
    logic sleep_reg;
    logic apd_reg;
    logic fpd_reg;
    logic atrk_reg;
    logic ftrk_reg;
    logic off_load;
    logic win_load;
    logic [15:0] win_val;
    logic chk_load;
    logic off_exp;
    logic win_exp;

    // Serial clock domain front end
    scx_spi_rx u_rx (
        .sclk(sclk),
        .cs_n(cs_n),
        .sdio_in(sdio_in),
        .link(link.rx)
    );

    // Synchronised copies of the single-bit signals from outside this clock domain
    wire [6:0] async_in = {agc_gain_switch, freq_slicer_in, ampl_slicer_in, link.rb_bit,
                           link.frame_done, sdio_in, cs_n};
    wire agc_s;
    wire freq_s;
    wire ampl_s;
    wire rb_s;
    wire done_s;
    wire io_s;
    wire cs_s;
    assign {agc_s, freq_s, ampl_s, rb_s, done_s, io_s, cs_s} = sync2_reg;
    wire cs_d;
    wire done_d;
    wire agc_d;
    assign {agc_d, done_d, cs_d} = edge_reg;

    // Two stages plus one for edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            edge_reg <= '0;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
            edge_reg <= {agc_s, done_s, cs_s};
        end
    end

    // Events and frame fields
    wire cs_fall = !cs_s && cs_d;
    wire cs_rise = cs_s && !cs_d;
    wire frame_ev = done_s && !done_d;
    wire agc_rise = agc_s && !agc_d;
    wire frame_ok = frame_ev && !drive_reg; // Read-back frames echo our own data
    wire [3:0] frm_cmd = link.frame_word[scx_pkg::CMD_MSB:scx_pkg::CMD_LSB];
    wire [3:0] frm_addr = link.frame_word[scx_pkg::ADDR_MSB:scx_pkg::ADDR_LSB];
    wire [7:0] frm_data = link.frame_word[scx_pkg::DATA_MSB:scx_pkg::DATA_LSB];
    wire wr_en = frame_ok && frm_cmd == scx_pkg::CMD_WRITE && frm_addr != scx_pkg::ADDR_STAT
                 && frm_addr <= scx_pkg::ADDR_DWELL;
    wire rd_cmd = frame_ok && frm_cmd == scx_pkg::CMD_READ;
    wire mr_cmd = frame_ok && frm_cmd == scx_pkg::CMD_MRESET;
    wire core_rst_n = rst_n && !mreset_reg;

    // Named register fields
    wire [7:0] pwr = regs_reg[scx_pkg::ADDR_PWR];
    wire [7:0] cfg = regs_reg[scx_pkg::ADDR_CFG];
    wire [7:0] ctl = regs_reg[scx_pkg::ADDR_CTL];
    wire [15:0] off_val = {regs_reg[scx_pkg::ADDR_OFF_HI], regs_reg[scx_pkg::ADDR_OFF_LO]};
    wire [15:0] rf_val = {regs_reg[scx_pkg::ADDR_RF_HI], regs_reg[scx_pkg::ADDR_RF_LO]};
    wire [7:0] cpu_val = regs_reg[scx_pkg::ADDR_CPU];
    wire sleep_bit = pwr[scx_pkg::PWR_SLEEP_BIT];
    wire drx_bit = cfg[scx_pkg::CFG_DRX_BIT];
    wire three_wire = !(cfg[scx_pkg::CFG_FREQ_RB_BIT] || cfg[scx_pkg::CFG_AMPL_RB_BIT]);
    wire [7:0] status_w = {5'h00, state_reg};

    // Read path; status is sampled live, so a read may catch it mid-change
    assign link.read_byte = (link.read_addr == scx_pkg::ADDR_STAT) ? status_w :
                            (link.read_addr <= scx_pkg::ADDR_DWELL) ? regs_reg[link.read_addr] :
                            scx_pkg::RST_ZERO;

    // Register file; the master reset holds it at power-on values
    always_ff @(posedge clk) begin
        if (!core_rst_n) begin
            for (int i = 0; i < scx_pkg::REG_COUNT; i++) begin
                regs_reg[i] <= scx_pkg::RST_ZERO; // [R9] [R24]
            end
            regs_reg[scx_pkg::ADDR_DWELL] <= scx_pkg::RST_DWELL;
        end else if (wr_en) begin
            regs_reg[frm_addr] <= frm_data; // [R25]
        end
    end

    // Master reset stays on until the next chip select fall
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mreset_reg <= 1'b0;
        end else if (mr_cmd) begin
            mreset_reg <= 1'b1; // [R9]
        end else if (cs_fall) begin
            mreset_reg <= 1'b0; // [R10]
        end
    end

    // Read command arms a drive window for the following select cycle
    always_ff @(posedge clk) begin
        if (!core_rst_n) begin
            arm_reg <= 1'b0;
            drive_reg <= 1'b0;
        end else begin
            if (rd_cmd) begin
                arm_reg <= 1'b1;
            end else if (cs_fall) begin
                arm_reg <= 1'b0;
            end
            if (cs_fall && arm_reg) begin
                drive_reg <= 1'b1; // [R6] [R7]
            end else if (cs_rise) begin
                drive_reg <= 1'b0; // [R8]
            end
        end
    end

    // Internal time base for the receive timers
    wire tick = (tick_cnt_reg == scx_pkg::TICK_LAST);
    always_ff @(posedge clk) begin
        if (!core_rst_n || tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 12'h001;
        end
    end

    // Off timer and the shared recovery and settle timer
    scx_timer #(.W(16)) u_off (
        .clk(clk),
        .rst_n(core_rst_n),
        .load(off_load),
        .load_val(off_val),
        .tick(tick),
        .expired(off_exp)
    );
    scx_timer #(.W(16)) u_win (
        .clk(clk),
        .rst_n(core_rst_n),
        .load(win_load),
        .load_val(win_val),
        .tick(tick),
        .expired(win_exp)
    );

    // Discontinuous receive sequence
    always_comb begin
        state_next = state_reg;
        off_load = 1'b0;
        win_load = 1'b0;
        win_val = 16'(cpu_val);
        chk_load = 1'b0;
        case (state_reg)
            scx_pkg::ST_IDLE: begin
                if (cs_s && io_s) begin // [R16]
                    state_next = scx_pkg::ST_OFF;
                    off_load = 1'b1;
                end
            end
            scx_pkg::ST_OFF: begin
                if (off_exp) begin // [R14] [R17]
                    state_next = scx_pkg::ST_CPU;
                    win_load = 1'b1;
                end
            end
            scx_pkg::ST_CPU: begin
                if (win_exp) begin // [R14]
                    state_next = scx_pkg::ST_RF;
                    win_load = 1'b1;
                    win_val = rf_val;
                end
            end
            scx_pkg::ST_RF: begin
                if (win_exp) begin // [R19]
                    state_next = scx_pkg::ST_CHECK;
                    chk_load = 1'b1;
                end
            end
            scx_pkg::ST_CHECK: begin
                if (chk_cnt_reg == '0) begin
                    if (io_s) begin // [R18] [R23]
                        state_next = scx_pkg::ST_OFF;
                        off_load = 1'b1;
                    end else begin
                        state_next = scx_pkg::ST_ACTIVE;
                    end
                end
            end
            scx_pkg::ST_ACTIVE: begin
                if (io_s && cs_s) begin // [R20]
                    state_next = scx_pkg::ST_OFF;
                    off_load = 1'b1;
                end
            end
            default: begin
                state_next = scx_pkg::ST_IDLE;
            end
        endcase
        if (!drx_bit) begin // [R1]
            state_next = scx_pkg::ST_IDLE;
            off_load = 1'b0;
            win_load = 1'b0;
            chk_load = 1'b0;
        end
    end

    // Wake handling and automatic track pulse
    wire wake_now = (state_reg == scx_pkg::ST_CHECK) && (state_next == scx_pkg::ST_ACTIVE);
    wire trk_start = wake_now || agc_rise;
    always_ff @(posedge clk) begin
        if (!core_rst_n) begin
            state_reg <= scx_pkg::ST_IDLE;
            chk_cnt_reg <= '0;
            trk_cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            chk_cnt_reg <= chk_load ? scx_pkg::CHECK_CYC :
                           (chk_cnt_reg != '0) ? chk_cnt_reg - 3'h1 : chk_cnt_reg;
            trk_cnt_reg <= trk_start ? scx_pkg::TRACK_CYC : // [R22]
                           (trk_cnt_reg != '0) ? trk_cnt_reg - 12'h001 : trk_cnt_reg;
        end
    end

    // Pin and power selection
    wire rb3 = drive_reg && three_wire;
    wire wake_drive = (state_reg == scx_pkg::ST_CPU) || (state_reg == scx_pkg::ST_RF);
    wire powered = !sleep_bit && (!drx_bit || state_reg == scx_pkg::ST_RF ||
                   state_reg == scx_pkg::ST_CHECK || state_reg == scx_pkg::ST_ACTIVE);
    wire run_ok = !sleep_bit && (!drx_bit || state_reg == scx_pkg::ST_ACTIVE);
    wire trk_auto = (trk_cnt_reg != '0);
    wire arb = drive_reg && cfg[scx_pkg::CFG_AMPL_RB_BIT];
    wire frb = drive_reg && cfg[scx_pkg::CFG_FREQ_RB_BIT];

    // Output flops
    always_ff @(posedge clk) begin
        if (!core_rst_n) begin
            sdio_out_reg <= 1'b0;
            sdio_oe_n_reg <= 1'b1;
            pullup_reg <= 1'b0;
            ampl_out_reg <= 1'b0;
            freq_out_reg <= 1'b0;
            power_reg <= '0;
            sleep_reg <= 1'b0;
            apd_reg <= 1'b0;
            fpd_reg <= 1'b0;
            atrk_reg <= 1'b0;
            ftrk_reg <= 1'b0;
        end else begin
            sdio_out_reg <= rb3 && rb_s; // [R5] [R6]
            sdio_oe_n_reg <= !(rb3 || wake_drive); // [R17]
            pullup_reg <= drx_bit; // [R16]
            ampl_out_reg <= arb ? rb_s : (run_ok && ampl_s); // [R4] [R19]
            freq_out_reg <= frb ? rb_s : (run_ok && freq_s); // [R4] [R19]
            power_reg <= powered ? pwr[scx_pkg::PWR_EN_MSB:scx_pkg::PWR_EN_LSB] : '0; // [R11] [R12]
            sleep_reg <= sleep_bit; // [R12]
            apd_reg <= run_ok && pwr[scx_pkg::PWR_APD_BIT];
            fpd_reg <= run_ok && pwr[scx_pkg::PWR_FPD_BIT];
            atrk_reg <= ctl[scx_pkg::CTL_AMPL_TRK_BIT] || trk_auto; // [R21]
            ftrk_reg <= ctl[scx_pkg::CTL_FREQ_TRK_BIT] || trk_auto; // [R21]
        end
    end

    assign sdio_out = sdio_out_reg;
    assign sdio_oe_n = sdio_oe_n_reg;
    assign sdio_pullup_en = pullup_reg;
    assign amplitude_data_output = ampl_out_reg;
    assign frequency_data_output = freq_out_reg;
    assign module_power = power_reg;
    assign deep_sleep = sleep_reg;
    assign ampl_peak_detector_enable = apd_reg;
    assign freq_peak_detector_enable = fpd_reg;
    assign ampl_peak_track = atrk_reg;
    assign freq_peak_track = ftrk_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_sleep_override: assert property (sleep_bit && !mreset_reg |=> module_power == '0 && deep_sleep) // [R12]
        else $error("deep sleep did not override power");
    a_cont_power: assert property (!drx_bit && !sleep_bit && !mreset_reg
            |=> module_power == $past(pwr[scx_pkg::PWR_EN_MSB:scx_pkg::PWR_EN_LSB])) // [R11]
        else $error("continuous mode power differs from enables");
    a_wake_drive: assert property (state_reg == scx_pkg::ST_OFF && off_exp && drx_bit && !mreset_reg
            |-> ##2 !sdio_oe_n && !sdio_out) // [R17]
        else $error("off expiry did not pull line low");
    a_outputs_gated: assert property (drx_bit && state_reg != scx_pkg::ST_ACTIVE && !drive_reg
            |=> !amplitude_data_output && !ampl_peak_detector_enable) // [R19]
        else $error("data output enabled before settle");
    a_mreset_hold: assert property (mreset_reg && !cs_fall |=> mreset_reg) // [R10]
        else $error("master reset released early");
    a_mreset_regs: assert property (mr_cmd |=> ##1 regs_reg[scx_pkg::ADDR_PWR] == scx_pkg::RST_ZERO
            && regs_reg[scx_pkg::ADDR_DWELL] == scx_pkg::RST_DWELL) // [R9]
        else $error("master reset did not restore registers");
    a_readback_drive: assert property (drive_reg && three_wire && !mreset_reg |=> !sdio_oe_n) // [R6]
        else $error("3-wire read-back not driven");
    a_write_store: assert property (wr_en && !mreset_reg |=> regs_reg[$past(frm_addr)] == $past(frm_data)) // [R25]
        else $error("write not stored");
    a_check_restart: assert property (state_reg == scx_pkg::ST_CHECK && chk_cnt_reg == '0 && io_s
            && drx_bit && !mreset_reg |=> state_reg == scx_pkg::ST_OFF) // [R23]
        else $error("missing host low did not restart");
    a_release_restart: assert property (state_reg == scx_pkg::ST_ACTIVE && io_s && cs_s && drx_bit
            && !mreset_reg |=> state_reg == scx_pkg::ST_OFF) // [R20]
        else $error("host release did not restart off timer");
    a_wake_track: assert property (wake_now && !mreset_reg |=> ##1 ampl_peak_track && freq_peak_track) // [R22]
        else $error("no track pulse on wake");
endmodule : scx_sequencer
`default_nettype wire

/* File: scx_host.sv */
// Host model driving the serial control lines
`timescale 1ns/10ps
`default_nettype none
module scx_host (
    // Serial lines
    output logic sclk,
    output logic cs_n,
    output logic h_en,
    output logic h_d,
    // Lines seen by the host
    input wire logic sdio,
    input wire logic a4
);
    // Idle: deselected with the line driven low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        h_en = 1'b1;
        h_d = 1'b0;
    end
    // One select cycle, MSB first, bit set half a period before rising edge
    task automatic xfer(input logic [15:0] w, input int n, input logic rel,
                        output logic [7:0] rd, output logic [7:0] ra);
        h_en = ~rel; // Let go for read-back
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            h_d = w[15-i];
            #62.5 sclk = 1'b1;
            rd = {rd[6:0], sdio};
            ra = {ra[6:0], a4};
            #62.5 sclk = 1'b0;
        end
        #62.5 cs_n = 1'b1;
        h_d = 1'b0;
        // Wait out the device's drive before taking the line back low
        #50 h_en = 1'b1;
        #300;
    endtask : xfer
    // Drive the line low, or let it go to the pull-up, while deselected
    task automatic hold(input logic en);
        h_d = 1'b0;
        h_en = en;
    endtask : hold
endmodule : scx_host
`default_nettype wire

/* File: testbench.sv */
// Directed testbench for the serial port and register file
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, cs_n, h_en, h_d, s_out, s_oe_n, pu, a_out, f_out, ds;
    logic [7:1] pwr;
    logic [7:0] rd, ra;
    logic apd, fpd, atk, ftk;
    logic sl = 1'b1;
    logic agc = 1'b0;
    int mismatches = 0;
    int num_checks = 0;
    // Undriven line without pull-up shows the inverse of the last host value
    wire sdio = !s_oe_n ? s_out : h_en ? h_d : pu | ~h_d;

    // Clock and instances
    always #5 clk = ~clk;
    scx_host i_host (.sclk(sclk), .cs_n(cs_n), .h_en(h_en), .h_d(h_d),
                     .sdio(sdio), .a4(a_out));
    scx_sequencer i_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .sdio_in(sdio), .sdio_out(s_out), .sdio_oe_n(s_oe_n), .sdio_pullup_en(pu),
        .ampl_slicer_in(sl), .freq_slicer_in(sl), .agc_gain_switch(agc),
        .amplitude_data_output(a_out), .frequency_data_output(f_out),
        .module_power(pwr), .deep_sleep(ds), .ampl_peak_detector_enable(apd),
        .freq_peak_detector_enable(fpd), .ampl_peak_track(atk), .freq_peak_track(ftk));

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait for an output level; running out counts as a mismatch
    task automatic wait_lvl(ref logic s, input logic v);
        int n = 0;
        while (s !== v) begin
            @(negedge clk);
            n++;
            if (n > 3000) begin
                mismatches++;
                $display("mismatch t=%0t wait for level timed out", $time);
                test_done();
            end
        end
    endtask : wait_lvl
    // Full frame, then a read-back cycle of n clocks
    task automatic op(input logic [15:0] w);
        i_host.xfer(w, 16, 1'b0, rd, ra);
    endtask : op
    task automatic rdb(input logic [3:0] a, input int n, input logic rel);
        op({scx_pkg::CMD_READ, a, 8'h00});
        i_host.xfer(16'h0000, n, rel, rd, ra);
    endtask : rdb
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        #100;
        chk(8'(s_oe_n), 8'h01);
        op(16'h1006);
        chk(8'(pwr), 8'h03);
        chk(8'({apd, fpd, a_out, f_out}), 8'h0f);
        op(16'h1007);
        chk({ds, pwr}, 8'h80);
        chk(8'({apd, fpd, a_out, f_out}), 8'h00);
        // Register track bit, then a gain switch adds a timed pulse on both
        op(16'h1202);
        chk(8'({atk, ftk}), 8'h02);
        @(negedge clk) agc = 1'b1;
        repeat (10) @(negedge clk);
        chk(8'({atk, ftk}), 8'h03);
        agc = 1'b0;
        repeat (2100) @(negedge clk);
        chk(8'({atk, ftk}), 8'h02);
        op(16'h135f);
        rdb(4'h3, 8, 1'b1);
        chk(rd, 8'h5f);
        rdb(4'h3, 16, 1'b1);
        chk(rd, 8'h5f);
        op(16'h4311);
        rdb(4'h3, 8, 1'b1);
        chk(rd, 8'h5f);
        op(16'h1104);
        rdb(4'h3, 16, 1'b0);
        chk(ra, 8'h5f);
        op(16'h3000);
        rdb(4'h3, 8, 1'b1);
        chk(rd, 8'h00);
        rdb(4'ha, 8, 1'b1);
        chk(rd, 8'h0d);
        // Discontinuous mode with one-tick timers; off registers start at zero
        op(16'h1501);
        op(16'h1601);
        op(16'h1801);
        op(16'h1101);
        i_host.hold(1'b0);
        wait_lvl(s_oe_n, 1'b0);
        chk(8'({pu, s_oe_n, sdio, a_out}), 8'h08);
        i_host.hold(1'b1);
        wait_lvl(a_out, 1'b1);
        chk(8'({a_out, f_out, atk, ftk}), 8'h0f);
        i_host.hold(1'b0);
        repeat (10) @(negedge clk);
        chk(8'(a_out), 8'h00);
        // No host low this time: the sequence must restart on its own
        wait_lvl(s_oe_n, 1'b0);
        wait_lvl(s_oe_n, 1'b1);
        wait_lvl(s_oe_n, 1'b0);
        chk(8'({s_oe_n, a_out}), 8'h00);
        test_done();
    end
    // Hang guard
    initial begin
        #1000000;
        mismatches++;
        test_done();
    end
endmodule : testbench
`default_nettype wire
